// [test_xap_top.sv]
/*
  Testbench for xap_top: pointer choice, address extension, decode, fast ports.
  Assumes the core model drives the SPECIAL_FUNCTION_REGISTER and move ports.
*/
`timescale 1ns/100ps
module test_xap_top;
  logic ref_clk;
  logic nrst;
  xap_pkg::xap_sfr_req_t sfr_req;
  xap_pkg::xap_move_t move;
  xap_pkg::xap_xaddr_t xaddr;
  logic [7:0] sfr_rdata;
  logic sfr_hit;
  logic ptr_select;
  logic [71:0] hub;
  logic [71:0] pins;
  logic [71:0] pin_out;
  int error_cnt;
  int n_compared;
  xap_top dut (.ref_clk(ref_clk), .nrst(nrst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit), .move(move), .xaddr(xaddr), .ptr_select(ptr_select),
    .hub_port_output(hub), .pin_in(pins), .pin_out(pin_out));
  xap_core_model core (.ref_clk(ref_clk), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .xaddr(xaddr), .sfr_req(sfr_req), .move(move));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // ==========================================================
  // checking
  task automatic cmp(input string n, input logic [71:0] e, input logic [71:0] g);
    n_compared++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input logic eh);
    logic [7:0] d;
    logic h;
    core.rd(a, d, h);
    cmp("sfr read", {64'h0, e}, {64'h0, d});
    cmp("sfr hit", {71'h0, eh}, {71'h0, h});
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_ptr;
    xap_pkg::xap_xaddr_t x;
    rdchk(xap_pkg::SFR_PTR_CHOICE, 8'h00, 1'b1);
    rdchk(8'h80, 8'h00, 1'b0);
    rdchk(8'hBB, 8'h00, 1'b0);
    core.wr(xap_pkg::SFR_PTR0_UPPER, 8'h3C);
    core.wr(xap_pkg::SFR_PTR1_UPPER, 8'hC5);
    core.mv(1'b0, 8'h11, 16'h1234, 16'hABCD, x);
    cmp("ptr0 addr", {48'h0, 8'h3C, 16'h1234}, {48'h0, x.addr});
    core.wr(xap_pkg::SFR_PTR_CHOICE, 8'h01);
    rdchk(xap_pkg::SFR_PTR_CHOICE, 8'h01, 1'b1);
    cmp("ptr select", 72'h1, {71'h0, ptr_select});
    core.mv(1'b0, 8'h11, 16'h1234, 16'hABCD, x);
    cmp("ptr1 addr", {48'h0, 8'hC5, 16'hABCD}, {48'h0, x.addr});
    core.wr(xap_pkg::SFR_PTR_CHOICE, 8'h00);
    $display("t_ptr done");
  endtask
  task automatic t_map;
    logic [23:0] a [13] = '{24'h004000, 24'h0042FF, 24'h004300, 24'h0044FF, 24'h005000,
      24'h005400, 24'h0054FF, 24'h005500, 24'h008000, 24'h080000, 24'h800000,
      24'hFFFFFF, 24'h5A6B7C};
    logic [8:0] r [13] = '{9'h002, 9'h002, 9'h004, 9'h008, 9'h010, 9'h020, 9'h020,
      9'h001, 9'h040, 9'h100, 9'h080, 9'h080, 9'h001};
    xap_pkg::xap_xaddr_t x;
    for (int i = 0; i < 13; i++) begin
      core.wr(xap_pkg::SFR_IND_TOP, a[i][23:16]);
      core.wr(xap_pkg::SFR_IND_PAGE, a[i][15:8]);
      core.mv(1'b1, a[i][7:0], 16'h0000, 16'hFFFF, x);
      cmp("move valid", 72'h1, {71'h0, x.valid});
      cmp("ri addr", {48'h0, a[i]}, {48'h0, x.addr});
      cmp("region", {63'h0, r[i]}, {63'h0, x.region});
    end
    $display("t_map done");
  endtask
  task automatic t_port;
    logic [7:0] b;
    logic [7:0] o;
    logic [7:0] e;
    for (int s = 0; s < 9; s++) begin
      b = 8'(xap_pkg::SFR_PORT_BASE + 3 * s);
      o = 8'hA5 ^ 8'(s);
      e = (o & 8'h0F) | (hub[s*8 +: 8] & 8'hF0);
      core.wr(b, o);
      core.wr(8'(b + 1), 8'h0F);
      rdchk(b, o, 1'b1);
      @(negedge ref_clk);
      cmp("pin out", {64'h0, e}, {64'h0, pin_out[s*8 +: 8]});
      core.wr(8'(b + 2), 8'hFF);
      rdchk(8'(b + 2), pins[s*8 +: 8], 1'b1);
      // all pins switched to the fast register
      core.wr(8'(b + 1), 8'hFF);
      rdchk(8'(b + 1), 8'hFF, 1'b1);
      cmp("pin out fast", {64'h0, o}, {64'h0, pin_out[s*8 +: 8]});
    end
    $display("t_port done");
  endtask
  // ==========================================================
  // main sequence
  initial begin
    error_cnt = 0;
    n_compared = 0;
    hub = 72'h3C_96_5A_E1_78_D2_4B_F0_1E;
    pins = 72'hC3_69_A5_1E_87_2D_B4_0F_E1;
    nrst = 1'b0;
    repeat (12) @(negedge ref_clk);
    nrst = 1'b1;
    t_ptr();
    t_map();
    t_port();
    close_out();
  end
endmodule

// [xap_core_model.sv]
/*
  CPU core model: issues SPECIAL_FUNCTION_REGISTER strobes and external data moves.
  Assumes the block samples on the rising edge; all drives change at the falling edge.
*/
`timescale 1ns/100ps
module xap_core_model (
  input wire logic ref_clk,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_hit,
  input wire xap_pkg::xap_xaddr_t xaddr,
  output xap_pkg::xap_sfr_req_t sfr_req,
  output xap_pkg::xap_move_t move
);
  initial begin
    sfr_req = '0;
    move = '0;
  end
  // ==========================================================
  // bus cycles; idle operands show inverted data so stale values cannot match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_req = '{1'b1, 1'b0, a, d};
    @(negedge ref_clk);
    sfr_req = '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(negedge ref_clk);
    sfr_req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge ref_clk);
    d = sfr_rdata;
    h = sfr_hit;
    sfr_req = '{1'b0, 1'b0, ~a, 8'hFF};
  endtask
  task automatic mv(input logic ri, input logic [7:0] v, input logic [15:0] p0,
                    input logic [15:0] p1, output xap_pkg::xap_xaddr_t x);
    @(negedge ref_clk);
    move = '{1'b1, ri, 1'b0, v, p0, p1};
    @(negedge ref_clk);
    x = xaddr;
    move = '{1'b0, ~ri, 1'b1, ~v, ~p0, ~p1};
  endtask
endmodule

// [xap_decode.sv]
/*
  Address region decoder for the 24-bit external-data space.
  Pure combinational; the top registers its outputs.
*/
`timescale 1ns/100ps
module xap_decode (
  input wire logic [23:0] addr,
  output logic [8:0] region
);
  function automatic logic in_rng(logic [23:0] a, logic [23:0] lo, logic [23:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // bit 8 marks the error-correction byte region (low byte zero there); otherwise the low byte is the one-hot class
  always_comb begin
    region = {1'b0, 8'(xap_pkg::XAP_RGN_NONE)};
    if (addr >= xap_pkg::EXT_LO) begin
      region = {1'b0, 8'(xap_pkg::XAP_RGN_EXT)};
    end else if (in_rng(addr, xap_pkg::CLK_LO, xap_pkg::CLK_HI)) begin
      region = {1'b0, 8'(xap_pkg::XAP_RGN_CLK)};
    end else if (in_rng(addr, xap_pkg::PWR_LO, xap_pkg::PWR_HI)) begin
      region = {1'b0, 8'(xap_pkg::XAP_RGN_PWR)};
    end else if (in_rng(addr, xap_pkg::INTC_LO, xap_pkg::INTC_HI)) begin
      region = {1'b0, 8'(xap_pkg::XAP_RGN_INTC)};
    end else if (in_rng(addr, xap_pkg::PORT_LO, xap_pkg::PORT_HI)) begin
      region = {1'b0, 8'(xap_pkg::XAP_RGN_PORT)};
    end else if (in_rng(addr, xap_pkg::EMC_LO, xap_pkg::EMC_HI)) begin
      region = {1'b0, 8'(xap_pkg::XAP_RGN_EMC)};
    end else if (in_rng(addr, xap_pkg::NVD_LO, xap_pkg::NVD_HI)) begin
      region = {1'b0, 8'(xap_pkg::XAP_RGN_NVD)};
    end else if (in_rng(addr, xap_pkg::ECC_LO, xap_pkg::ECC_HI)) begin
      region = {1'b1, xap_pkg::ECC_CODE};
    end
  end
endmodule

// [xap_pkg.sv]
/*
  Package for the external-data address extension and fast port block.
  Assumes one CPU clock domain; the CPU core presents its own SPECIAL_FUNCTION_REGISTER strobes.
*/
package xap_pkg;
  // ==========================================================
  // special-function register offsets (chosen within SPECIAL_FUNCTION_REGISTER space)
  localparam logic [7:0] SFR_PTR_CHOICE = 8'h86;
  localparam logic [7:0] SFR_PTR0_UPPER = 8'h93;
  localparam logic [7:0] SFR_PTR1_UPPER = 8'h95;
  localparam logic [7:0] SFR_IND_TOP = 8'hEA;
  localparam logic [7:0] SFR_IND_PAGE = 8'hF3;
  // fast port registers: base + 3*slot, slot 0..8
  localparam logic [7:0] SFR_PORT_BASE = 8'hA0;
  localparam int PORT_STRIDE = 3;
  localparam int NUM_FPORTS = 9;
  localparam logic [1:0] FP_OUT = 2'h0;
  localparam logic [1:0] FP_SEL = 2'h1;
  localparam logic [1:0] FP_PIN = 2'h2;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int CHOICE_BIT = 0;

  // ==========================================================
  // address map, 24-bit space
  localparam logic [23:0] CLK_LO = 24'h004000;
  localparam logic [23:0] CLK_HI = 24'h0042FF;
  localparam logic [23:0] PWR_LO = 24'h004300;
  localparam logic [23:0] PWR_HI = 24'h0043FF;
  localparam logic [23:0] INTC_LO = 24'h004400;
  localparam logic [23:0] INTC_HI = 24'h0044FF;
  localparam logic [23:0] PORT_LO = 24'h005000;
  localparam logic [23:0] PORT_HI = 24'h0051FF;
  localparam logic [23:0] EMC_LO = 24'h005400;
  localparam logic [23:0] EMC_HI = 24'h0054FF;
  localparam logic [23:0] NVD_LO = 24'h008000;
  localparam logic [23:0] NVD_HI = 24'h008FFF;
  localparam logic [23:0] ECC_LO = 24'h080000;
  localparam logic [23:0] ECC_HI = 24'h081FFF;
  localparam logic [23:0] EXT_LO = 24'h800000;

  typedef enum logic [7:0] {
    XAP_RGN_NONE = 8'h01,
    XAP_RGN_CLK = 8'h02,
    XAP_RGN_PWR = 8'h04,
    XAP_RGN_INTC = 8'h08,
    XAP_RGN_PORT = 8'h10,
    XAP_RGN_EMC = 8'h20,
    XAP_RGN_NVD = 8'h40,
    XAP_RGN_EXT = 8'h80
  } xap_region_t;
  localparam logic [7:0] ECC_CODE = 8'h00;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } xap_sfr_req_t;

  // xdata move request from the core
  typedef struct packed {
    logic valid;
    logic via_ri;
    logic sel_r1;
    logic [7:0] ri_val;
    logic [15:0] data_pointer_zero;
    logic [15:0] data_pointer_one;
  } xap_move_t;

  typedef struct packed {
    logic valid;
    logic [23:0] addr;
    logic [8:0] region;
  } xap_xaddr_t;
endpackage

// [xap_top.sv]
/*
  External-data address extension, dual pointer choice and fast port SFRs.
  Assumes the core gives one-cycle SPECIAL_FUNCTION_REGISTER strobes and presents move operands
  for one cycle with valid; port pins and hub data are synchronous.
*/
// Contract
// - pointer choice register selects active pointer
// - pointer moves take top byte from extension
// - register moves use top and page bytes
// - extensions apply only to external moves
// - external addresses are 24 bits wide
// - fast output register for nine ports
// - select one drives pin from fast output
// - select zero drives pin from hub data
// - pin state readable, writes ignored
// - only subset of port registers here
// - decode clock, power, interrupt regions
// - decode port, nonvolatile, correction regions
// - decode memory interface control window
// - top half goes off chip
`timescale 1ns/100ps
module xap_top #(
  parameter int NPORT = xap_pkg::NUM_FPORTS,
  parameter int PW = 8
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire xap_pkg::xap_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  input wire xap_pkg::xap_move_t move,
  output xap_pkg::xap_xaddr_t xaddr,
  output logic ptr_select,
  input wire logic [NPORT*PW-1:0] hub_port_output,
  input wire logic [NPORT*PW-1:0] pin_in,
  output logic [NPORT*PW-1:0] pin_out
);
  // ==========================================================
  // register state
  logic choice_r, choice_nxt;
  logic [7:0] up0_r, up0_nxt, up1_r, up1_nxt, top_r, top_nxt, page_r, page_nxt;
  logic [PW-1:0] fout_r [NPORT];
  logic [PW-1:0] fout_nxt [NPORT];
  logic [PW-1:0] fsel_r [NPORT];
  logic [PW-1:0] fsel_nxt [NPORT];
  logic [NPORT*PW-1:0] pin_out_nxt;
  logic [7:0] rdata_nxt;
  logic hit_nxt;
  xap_pkg::xap_xaddr_t xaddr_nxt;
  logic [23:0] addr_c;
  logic [8:0] region_c;

  // which fast-port slot and kind an SPECIAL_FUNCTION_REGISTER address falls on
  function automatic logic port_hit(logic [7:0] a, int p, logic [1:0] k);
    return a == 8'(int'(xap_pkg::SFR_PORT_BASE) + p * xap_pkg::PORT_STRIDE + int'(k));
  endfunction

  // ==========================================================
  // SPECIAL_FUNCTION_REGISTER writes
  always_comb begin
    choice_nxt = choice_r;
    up0_nxt = up0_r;
    up1_nxt = up1_r;
    top_nxt = top_r;
    page_nxt = page_r;
    for (int p = 0; p < NPORT; p++) begin
      fout_nxt[p] = fout_r[p];
      fsel_nxt[p] = fsel_r[p];
    end
    if (sfr_req.wr) begin
      unique case (sfr_req.addr)
        xap_pkg::SFR_PTR_CHOICE: choice_nxt = sfr_req.wdata[xap_pkg::CHOICE_BIT];
        xap_pkg::SFR_PTR0_UPPER: up0_nxt = sfr_req.wdata;
        xap_pkg::SFR_PTR1_UPPER: up1_nxt = sfr_req.wdata;
        xap_pkg::SFR_IND_TOP: top_nxt = sfr_req.wdata;
        xap_pkg::SFR_IND_PAGE: page_nxt = sfr_req.wdata;
        default: begin
          // pin-state slot has no write path: writes there are dropped
          for (int p = 0; p < NPORT; p++) begin
            if (port_hit(sfr_req.addr, p, xap_pkg::FP_OUT)) begin
              fout_nxt[p] = sfr_req.wdata;
            end
            if (port_hit(sfr_req.addr, p, xap_pkg::FP_SEL)) begin
              fsel_nxt[p] = sfr_req.wdata;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // SPECIAL_FUNCTION_REGISTER reads (registered, valid the cycle after rd)
  always_comb begin
    rdata_nxt = 8'h00;
    hit_nxt = 1'b0;
    if (sfr_req.rd) begin
      hit_nxt = 1'b1;
      unique case (sfr_req.addr)
        xap_pkg::SFR_PTR_CHOICE: rdata_nxt = {7'h00, choice_r};
        xap_pkg::SFR_PTR0_UPPER: rdata_nxt = up0_r;
        xap_pkg::SFR_PTR1_UPPER: rdata_nxt = up1_r;
        xap_pkg::SFR_IND_TOP: rdata_nxt = top_r;
        xap_pkg::SFR_IND_PAGE: rdata_nxt = page_r;
        default: begin
          hit_nxt = 1'b0;
          // only output, select and pin state live here; the rest via the hub
          for (int p = 0; p < NPORT; p++) begin
            if (port_hit(sfr_req.addr, p, xap_pkg::FP_OUT)) begin
              rdata_nxt = fout_r[p];
              hit_nxt = 1'b1;
            end
            if (port_hit(sfr_req.addr, p, xap_pkg::FP_SEL)) begin
              rdata_nxt = fsel_r[p];
              hit_nxt = 1'b1;
            end
            if (port_hit(sfr_req.addr, p, xap_pkg::FP_PIN)) begin
              rdata_nxt = pin_in[p*PW +: PW];
              hit_nxt = 1'b1;
            end
          end
        end
      endcase
    end
  end
  // unmapped SPECIAL_FUNCTION_REGISTER reads return zero with sfr_hit low

  // ==========================================================
  // pin output mux
  genvar g;
  generate
    for (g = 0; g < NPORT; g++) begin : g_pin
      // per-bit choice between fast and hub data
      assign pin_out_nxt[g*PW +: PW] =
          (fsel_r[g] & fout_r[g]) | (~fsel_r[g] & hub_port_output[g*PW +: PW]);
    end
  endgenerate

  // ==========================================================
  // external address formation
  always_comb begin
    if (move.via_ri) begin
      addr_c = {top_r, page_r, move.ri_val};
    end else if (choice_r) begin
      addr_c = {up1_r, move.data_pointer_one};
    end else begin
      addr_c = {up0_r, move.data_pointer_zero};
    end
  end

  xap_decode u_dec (
    .addr(addr_c),
    .region(region_c)
  );

  always_comb begin
    // only external moves raise valid; other instructions never see extensions
    xaddr_nxt.valid = move.valid;
    xaddr_nxt.addr = move.valid ? addr_c : 24'h000000;
    xaddr_nxt.region = move.valid ? region_c : 9'h000;
  end

  // ==========================================================
  // registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      choice_r <= 1'b0;
      up0_r <= xap_pkg::REG_RESET;
      up1_r <= xap_pkg::REG_RESET;
      top_r <= xap_pkg::REG_RESET;
      page_r <= xap_pkg::REG_RESET;
      for (int p = 0; p < NPORT; p++) begin
        fout_r[p] <= '0;
        fsel_r[p] <= '0;
      end
      pin_out <= '0;
      sfr_rdata <= 8'h00;
      sfr_hit <= 1'b0;
      xaddr <= '0;
      ptr_select <= 1'b0;
    end else begin
      choice_r <= choice_nxt;
      up0_r <= up0_nxt;
      up1_r <= up1_nxt;
      top_r <= top_nxt;
      page_r <= page_nxt;
      for (int p = 0; p < NPORT; p++) begin
        fout_r[p] <= fout_nxt[p];
        fsel_r[p] <= fsel_nxt[p];
      end
      pin_out <= pin_out_nxt;
      sfr_rdata <= rdata_nxt;
      sfr_hit <= hit_nxt;
      xaddr <= xaddr_nxt;
      ptr_select <= choice_nxt;
    end
  end

  // ==========================================================
  // checks
  chk_ptr_top_byte: assert property (@(posedge ref_clk) disable iff (!nrst)
    move.valid && !move.via_ri && !choice_r |=> xaddr.addr[23:16] == $past(up0_r))
    else $error("pointer zero top byte wrong");
  chk_ptr1_low: assert property (@(posedge ref_clk) disable iff (!nrst)
    move.valid && !move.via_ri && choice_r |=> xaddr.addr == {$past(up1_r), $past(move.data_pointer_one)})
    else $error("pointer one address wrong");
  chk_ri_addr: assert property (@(posedge ref_clk) disable iff (!nrst)
    move.valid && move.via_ri |=> xaddr.addr == {$past(top_r), $past(page_r), $past(move.ri_val)})
    else $error("register indirect address wrong");
  chk_no_move: assert property (@(posedge ref_clk) disable iff (!nrst)
    !move.valid |=> !xaddr.valid && xaddr.addr == 24'h000000)
    else $error("address driven outside move");
  chk_ext_region: assert property (@(posedge ref_clk) disable iff (!nrst)
    xaddr.valid && xaddr.addr >= xap_pkg::EXT_LO |-> xaddr.region == {1'b0, 8'(xap_pkg::XAP_RGN_EXT)})
    else $error("upper half not off chip");
  chk_emc_window: assert property (@(posedge ref_clk) disable iff (!nrst)
    xaddr.valid && xaddr.addr[23:8] == xap_pkg::EMC_LO[23:8]
      |-> xaddr.region == {1'b0, 8'(xap_pkg::XAP_RGN_EMC)})
    else $error("memory interface window missed");
  chk_choice_wr: assert property (@(posedge ref_clk) disable iff (!nrst)
    sfr_req.wr && sfr_req.addr == xap_pkg::SFR_PTR_CHOICE
      |=> ptr_select == $past(sfr_req.wdata[xap_pkg::CHOICE_BIT]))
    else $error("pointer choice not written");
  chk_pin_mux: assert property (@(posedge ref_clk) disable iff (!nrst)
    fsel_r[0] == 8'hFF && $stable(fsel_r[0]) |=> pin_out[7:0] == $past(fout_r[0]))
    else $error("fast output not on pins");
  chk_hub_mux: assert property (@(posedge ref_clk) disable iff (!nrst)
    fsel_r[0] == 8'h00 && $stable(fsel_r[0]) |=> pin_out[7:0] == $past(hub_port_output[7:0]))
    else $error("hub data not on pins");
  chk_pin_state: assert property (@(posedge ref_clk) disable iff (!nrst)
    sfr_req.rd && sfr_req.addr == xap_pkg::SFR_PORT_BASE + 8'(xap_pkg::FP_PIN)
      |=> sfr_hit && sfr_rdata == $past(pin_in[7:0]))
    else $error("pin state read wrong");
endmodule
